// ==== pkg/irq_ctl_pkg.sv ====
// package: register map, reset values and carriers for the interrupt control slice
package irq_ctl_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int NUM_EXT = 5;
	localparam int NUM_WAKEUP = 8;
	localparam int NUM_SRC = 16;

	// register offsets on the cpu bus
	localparam logic [15:0] OFS_EDGE_POLARITY = 16'hfff2;
	localparam logic [15:0] OFS_ENABLE_ONE    = 16'hfff3;
	localparam logic [15:0] OFS_ENABLE_TWO    = 16'hfff4;
	localparam logic [15:0] OFS_REQUEST_ONE   = 16'hfff6;
	localparam logic [15:0] OFS_REQUEST_TWO   = 16'hfff7;
	localparam logic [15:0] OFS_WAKEUP_REQ    = 16'hfff9;

	// reset values and bits that always read as one
	localparam logic [7:0] RST_EDGE_POLARITY = 8'he0;
	localparam logic [7:0] RST_ENABLE        = 8'h00;
	localparam logic [7:0] RST_REQUEST_ONE   = 8'h20;
	localparam logic [7:0] RST_REQUEST_TWO   = 8'h00;
	localparam logic [7:0] RST_WAKEUP_REQ    = 8'h00;
	localparam logic [7:0] EDGE_FIXED_ONES   = 8'he0;
	localparam logic [7:0] REQ_ONE_FIXED_ONES = 8'h20;
	localparam logic       EXT_PIN_IDLE      = 1'b1;

	// bit positions of enable/request group one
	localparam int BIT_TIMER_A    = 7;
	localparam int BIT_SERIAL_ONE = 6;
	localparam int BIT_WAKEUP     = 5;
	localparam int BIT_EXT_BASE   = 0;

	// bit positions of enable/request group two
	localparam int BIT_DIRECT_XFER = 7;
	localparam int BIT_ADC_DONE    = 6;
	localparam int BIT_SERIAL_TWO  = 5;
	localparam int BIT_TIMER_G     = 4;
	localparam int BIT_TIMER_FH    = 3;
	localparam int BIT_TIMER_FL    = 2;
	localparam int BIT_TIMER_C     = 1;
	localparam int BIT_TIMER_B     = 0;

	// source index in o_src_req, highest priority first
	localparam int SRC_EXT_BASE   = 0;
	localparam int SRC_WAKEUP     = 5;
	localparam int SRC_SERIAL_ONE = 6;
	localparam int SRC_TIMER_A    = 7;
	localparam int SRC_GROUP_TWO  = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

	// one-cycle event pulses from the peripherals
	typedef struct packed {
		logic timer_a_ovf;
		logic serial_one_done;
		logic timer_b_ovf;
		logic timer_c_ovf_udf;
		logic timer_fl_match;
		logic timer_fl_ovf;
		logic timer_fh_match;
		logic timer_fh_ovf;
		logic timer_g_capture;
		logic timer_g_ovf;
		logic serial_two_done;
		logic serial_two_abort;
		logic adc_done;
		logic direct_xfer;
	} periph_evt_t;

endpackage

// ==== rtl/ext_edge_sense.sv ====
// edge detector for one external interrupt line
`timescale 1ns/1ns
`default_nettype none
module ext_edge_sense
	import irq_ctl_pkg::*;
(
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_arst_n,
	// line and selection
	input  wire logic i_line,
	input  wire logic i_sel_rising,
	input  wire logic i_irq_mode,
	// detected edge, same cycle
	output logic      o_hit
);

	logic prev;

	// idle-high reset keeps a high line at release from faking a rising edge
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prev <= EXT_PIN_IDLE;
		end else begin
			prev <= i_line;
		end
	end

	always_comb begin
		if (!i_irq_mode) begin
			o_hit = 1'b0;
		end else if (i_sel_rising) begin
			o_hit = ~prev & i_line;
		end else begin
			o_hit = prev & ~i_line;
		end
	end

endmodule // ext_edge_sense
`default_nettype wire

// ==== rtl/irq_edge_select_and_enable.sv ====
// interrupt edge select, enable and request flag registers
// Notes on behaviour
// - eight-bit edge register, low five bits select
// - edge register bits 7..5 read one, fixed
// - select zero falling, one rising; resets zero
// - select bit four steers line four (adc trigger)
// - select bit three steers line three (timer f)
// - select bit two steers line two (timer c)
// - select bit one steers line one (timer b)
// - select bit zero steers dedicated line zero
// - enable register one, read/write, resets zero
// - enable one bit 7 gates timer a
// - enable one bit 6 gates serial one
// - enable one bit 5 gates all wakeups
// - enable one bits 4..0 gate external lines
// - enable register two, read/write, resets zero
// - enable two bit 7 gates direct transfer
// - enable two bit 6 gates adc done
// - enable two bit 5 gates serial two
// - enable two bit 4 gates timer g
// - enable two bit 3 gates timer fh
// - enable two bit 2 gates timer fl
// - enable two bit 1 gates timer c
// - enable two bit 0 gates timer b
// - chosen edge on interrupt-mode pin sets flag
// - flags cleared by writing zero only
// - cpu mask blocks acceptance, flags still set
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module irq_edge_select_and_enable
	import irq_ctl_pkg::*;
(
	// clock and reset
	input  wire logic                    i_mclk,
	input  wire logic                    i_arst_n,
	// register port
	input  wire reg_req_t                i_bus,
	output logic [DATA_W-1:0]            o_rdata,
	// external lines and their pin mode
	input  wire logic [NUM_EXT-1:0]      i_ext_line,
	input  wire logic [NUM_EXT-1:0]      i_ext_irq_mode,
	// event pulses
	input  wire logic [NUM_WAKEUP-1:0]   i_wakeup_evt,
	input  wire periph_evt_t             i_periph,
	// processor side
	input  wire logic                    i_cpu_mask,
	output logic [NUM_SRC-1:0]           o_src_req,
	output logic                         o_int_req
);

	logic [NUM_EXT-1:0]    edge_sel;
	logic [7:0]            enable_one;
	logic [7:0]            enable_two;
	logic [7:0]            request_one;
	logic [7:0]            request_two;
	logic [NUM_WAKEUP-1:0] wakeup_flag;
	logic [NUM_EXT-1:0]    ext_hit;
	logic [7:0]            set_one;
	logic [7:0]            set_two;
	logic [7:0]            next_rdata;

	function automatic logic reg_wr(input reg_req_t req, input logic [ADDR_W-1:0] ofs);
		reg_wr = req.wr && (req.addr == ofs);
	endfunction

	// writing one keeps a flag, zero clears, a new event wins over the clear
	function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] set,
			input logic hit, input logic [7:0] wd);
		flag_next = (hit ? (cur & wd) : cur) | set;
	endfunction

	// edge detection, one instance per external line
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
			ext_edge_sense u_sense (
				.i_mclk       (i_mclk),
				.i_arst_n     (i_arst_n),
				.i_line       (i_ext_line[gi]),
				.i_sel_rising (edge_sel[gi]),
				.i_irq_mode   (i_ext_irq_mode[gi]),
				.o_hit        (ext_hit[gi])
			);
		end
	endgenerate

	// edge select register
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			edge_sel <= RST_EDGE_POLARITY[NUM_EXT-1:0];
		end else if (reg_wr(i_bus, OFS_EDGE_POLARITY)) begin
			edge_sel <= i_bus.wdata[NUM_EXT-1:0];
		end
	end

	// enable registers
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			enable_one <= RST_ENABLE;
		end else if (reg_wr(i_bus, OFS_ENABLE_ONE)) begin
			enable_one <= i_bus.wdata;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			enable_two <= RST_ENABLE;
		end else if (reg_wr(i_bus, OFS_ENABLE_TWO)) begin
			enable_two <= i_bus.wdata;
		end
	end

	// request flag set terms
	always_comb begin
		set_one = 8'h00;
		set_one[BIT_TIMER_A] = i_periph.timer_a_ovf;
		set_one[BIT_SERIAL_ONE] = i_periph.serial_one_done;
		set_one[BIT_EXT_BASE +: NUM_EXT] = ext_hit;
		set_two = 8'h00;
		set_two[BIT_DIRECT_XFER] = i_periph.direct_xfer;
		set_two[BIT_ADC_DONE] = i_periph.adc_done;
		set_two[BIT_SERIAL_TWO] = i_periph.serial_two_done | i_periph.serial_two_abort;
		set_two[BIT_TIMER_G] = i_periph.timer_g_capture | i_periph.timer_g_ovf;
		set_two[BIT_TIMER_FH] = i_periph.timer_fh_match | i_periph.timer_fh_ovf;
		set_two[BIT_TIMER_FL] = i_periph.timer_fl_match | i_periph.timer_fl_ovf;
		set_two[BIT_TIMER_C] = i_periph.timer_c_ovf_udf;
		set_two[BIT_TIMER_B] = i_periph.timer_b_ovf;
	end

	// flags hold through acceptance; the mask does not stop them setting
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			request_one <= RST_REQUEST_ONE;
		end else begin
			request_one <= flag_next(request_one, set_one,
				reg_wr(i_bus, OFS_REQUEST_ONE), i_bus.wdata);
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			request_two <= RST_REQUEST_TWO;
		end else begin
			request_two <= flag_next(request_two, set_two,
				reg_wr(i_bus, OFS_REQUEST_TWO), i_bus.wdata);
		end
	end

	// wakeup edges are detected at the pins; only the flags live here
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wakeup_flag <= RST_WAKEUP_REQ;
		end else begin
			wakeup_flag <= flag_next(wakeup_flag, i_wakeup_evt,
				reg_wr(i_bus, OFS_WAKEUP_REQ), i_bus.wdata);
		end
	end

	// read data, valid only in the cycle after the read strobe
	always_comb begin
		next_rdata = 8'h00;
		if (i_bus.rd) begin
			case (i_bus.addr)
				OFS_EDGE_POLARITY: next_rdata = EDGE_FIXED_ONES | {3'h0, edge_sel};
				OFS_ENABLE_ONE:    next_rdata = enable_one;
				OFS_ENABLE_TWO:    next_rdata = enable_two;
				OFS_REQUEST_ONE:   next_rdata = request_one | REQ_ONE_FIXED_ONES;
				OFS_REQUEST_TWO:   next_rdata = request_two;
				OFS_WAKEUP_REQ:    next_rdata = wakeup_flag;
				default:           next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= next_rdata;
		end
	end

	// per-source requests; combinational from flag and enable flip-flops
	generate
		for (gi = 0; gi < NUM_EXT; gi++) begin : g_req_ext
			assign o_src_req[SRC_EXT_BASE + gi] =
				request_one[BIT_EXT_BASE + gi] & enable_one[BIT_EXT_BASE + gi];
		end
		// group two maps bit for bit in priority order: bit 0 is timer b
		for (gi = 0; gi < 8; gi++) begin : g_req_two
			assign o_src_req[SRC_GROUP_TWO + gi] =
				request_two[gi] & enable_two[gi];
		end
	endgenerate

	assign o_src_req[SRC_WAKEUP] = (|wakeup_flag) & enable_one[BIT_WAKEUP];
	assign o_src_req[SRC_SERIAL_ONE] =
		request_one[BIT_SERIAL_ONE] & enable_one[BIT_SERIAL_ONE];
	assign o_src_req[SRC_TIMER_A] = request_one[BIT_TIMER_A] & enable_one[BIT_TIMER_A];

	// the core masks acceptance; the pending view stays visible in o_src_req
	assign o_int_req = (|o_src_req) & ~i_cpu_mask;

	// checks on the register and flag behaviour
	property p_edge_fixed_ones;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_bus.rd && i_bus.addr == OFS_EDGE_POLARITY) |=> (o_rdata[7:5] == 3'b111);
	endproperty
	a_edge_fixed_ones: assert property (p_edge_fixed_ones) else $error("edge register top bits not one");

	property p_edge_readback;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_bus.wr && i_bus.addr == OFS_EDGE_POLARITY) ##1 (i_bus.rd && i_bus.addr == OFS_EDGE_POLARITY)
		|=> (o_rdata[4:0] == $past(i_bus.wdata[4:0], 2));
	endproperty
	a_edge_readback: assert property (p_edge_readback) else $error("edge select readback wrong");

	property p_fall_sets_line0;
		@(posedge i_mclk) disable iff (!i_arst_n)
		($past(i_ext_line[0]) && !i_ext_line[0] && i_ext_irq_mode[0] && !edge_sel[0])
		|=> request_one[0];
	endproperty
	a_fall_sets_line0: assert property (p_fall_sets_line0) else $error("falling edge missed on line 0");

	property p_rise_sets_line4;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(!$past(i_ext_line[4]) && i_ext_line[4] && i_ext_irq_mode[4] && edge_sel[4])
		|=> request_one[4];
	endproperty
	a_rise_sets_line4: assert property (p_rise_sets_line4) else $error("rising edge missed on line 4");

	property p_wrong_edge_quiet;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(!request_one[2] && $past(i_ext_line[2]) && !i_ext_line[2] && edge_sel[2])
		|=> !request_one[2];
	endproperty
	a_wrong_edge_quiet: assert property (p_wrong_edge_quiet) else $error("line 2 set on unselected edge");

	property p_mode_off_quiet;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(!i_ext_irq_mode[1] && !request_one[1]) |=> !request_one[1];
	endproperty
	a_mode_off_quiet: assert property (p_mode_off_quiet) else $error("line 1 set while not in irq mode");

	property p_write_one_keeps;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_bus.wr && i_bus.addr == OFS_REQUEST_TWO && i_bus.wdata == 8'hff)
		|=> (($past(request_two) & ~request_two) == 8'h00);
	endproperty
	a_write_one_keeps: assert property (p_write_one_keeps) else $error("writing one dropped a flag");

	property p_set_beats_clear;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_bus.wr && i_bus.addr == OFS_REQUEST_TWO && !i_bus.wdata[BIT_ADC_DONE] && i_periph.adc_done)
		|=> request_two[BIT_ADC_DONE] ##1 (request_two[BIT_ADC_DONE] || $past(i_bus.wr));
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear) else $error("event lost to a clear");

	property p_mask_blocks;
		@(posedge i_mclk) disable iff (!i_arst_n)
		i_cpu_mask |-> !o_int_req;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks) else $error("request passed the cpu mask");

	property p_disable_drops;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_bus.wr && i_bus.addr == OFS_ENABLE_TWO && !i_bus.wdata[BIT_ADC_DONE])
		|=> !o_src_req[SRC_GROUP_TWO + BIT_ADC_DONE];
	endproperty
	a_disable_drops: assert property (p_disable_drops) else $error("adc request despite disable");

	property p_wakeup_common;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_wakeup_evt[3] && enable_one[BIT_WAKEUP] && !(i_bus.wr && i_bus.addr == OFS_ENABLE_ONE))
		|=> o_src_req[SRC_WAKEUP];
	endproperty
	a_wakeup_common: assert property (p_wakeup_common) else $error("wakeup request not raised");

endmodule // irq_edge_select_and_enable
`default_nettype wire

// ==== tb/periph_src_model.sv ====
// event source model standing in for the peripherals and wakeup pins
`timescale 1ns/1ns
`default_nettype none
module periph_src_model
	import irq_ctl_pkg::*;
(
	// clock and reset
	input  wire logic                  i_mclk,
	input  wire logic                  i_arst_n,
	// command from the bench
	input  wire logic                  i_fire,
	input  wire logic [4:0]            i_sel,
	// event pulses toward the block
	output var  periph_evt_t           o_periph,
	output var  logic [NUM_WAKEUP-1:0] o_wakeup
);
	logic [21:0] pulse;

	// one pulse cycle per cycle of i_fire, one cycle a command here, as the real peripherals do
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pulse <= '0;
		end else begin
			pulse <= i_fire ? (22'h1 << i_sel) : '0;
		end
	end

	assign o_periph = periph_evt_t'(pulse[13:0]);
	assign o_wakeup = pulse[21:14];
endmodule // periph_src_model
`default_nettype wire

// ==== tb/tb_irq_edge_select_and_enable.sv ====
// self-checking bench for the interrupt edge select and enable slice
`timescale 1ns/1ns
`default_nettype none
module tb_irq_edge_select_and_enable
	import irq_ctl_pkg::*;
;
	logic        mclk;
	logic        arst_n;
	reg_req_t    bus;
	logic [4:0]  ext_line;
	logic [4:0]  ext_mode;
	logic        cpu_mask;
	logic        fire_cmd;
	logic [4:0]  sel;
	periph_evt_t periph;
	logic [7:0]  wakeup;
	logic [7:0]  rdata;
	logic [15:0] src_req;
	logic        int_req;
	int          err_count;
	int          n_checks;
	// source index of each event bit, lowest struct bit first
	localparam int src_of [14] = '{15, 14, 13, 13, 12, 12, 11, 11, 10, 10, 9, 8, 6, 7};

	irq_edge_select_and_enable u_dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_bus(bus), .o_rdata(rdata),
		.i_ext_line(ext_line), .i_ext_irq_mode(ext_mode), .i_wakeup_evt(wakeup), .i_periph(periph),
		.i_cpu_mask(cpu_mask), .o_src_req(src_req), .o_int_req(int_req));
	periph_src_model u_src (.i_mclk(mclk), .i_arst_n(arst_n), .i_fire(fire_cmd), .i_sel(sel),
		.o_periph(periph), .o_wakeup(wakeup));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// writes land at the second edge; sample just after it
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
		#1;
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] exp, input string msg);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		chk({8'h00, rdata}, {8'h00, exp}, msg);
	endtask

	// command, model pulse, flag: three edges
	task automatic fire(input int s);
		@(posedge mclk);
		fire_cmd <= 1'b1;
		sel <= 5'(s);
		@(posedge mclk);
		fire_cmd <= 1'b0;
		@(posedge mclk);
		#1;
	endtask

	task automatic line_to(input int i, input logic v);
		@(posedge mclk);
		ext_line[i] <= v;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic t_reset();
		rchk(OFS_EDGE_POLARITY, 8'he0, "edge reset");
		rchk(OFS_ENABLE_ONE, 8'h00, "enable one reset");
		rchk(OFS_ENABLE_TWO, 8'h00, "enable two reset");
		chk(src_req, 16'h0000, "requests after reset");
		$display("test reset done");
	endtask

	task automatic t_regs();
		// write then read with no gap between the strobes
		@(posedge mclk);
		bus <= '{addr: OFS_EDGE_POLARITY, wdata: 8'h15, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus <= '{addr: OFS_EDGE_POLARITY, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		chk({8'h00, rdata}, 16'h00f5, "back to back readback");
		wr(OFS_EDGE_POLARITY, 8'h1f);
		rchk(OFS_EDGE_POLARITY, 8'hff, "edge all set");
		wr(OFS_EDGE_POLARITY, 8'h0a);
		rchk(OFS_EDGE_POLARITY, 8'hea, "fixed ones kept");
		wr(OFS_ENABLE_ONE, 8'ha5);
		wr(OFS_ENABLE_TWO, 8'h5a);
		rchk(OFS_ENABLE_ONE, 8'ha5, "enable one rw");
		rchk(OFS_ENABLE_TWO, 8'h5a, "enable two rw");
		rchk(16'h0010, 8'h00, "unmapped read");
		wr(OFS_ENABLE_ONE, 8'h00);
		wr(OFS_ENABLE_TWO, 8'h00);
		$display("test registers done");
	endtask

	task automatic t_ext();
		for (int i = 0; i < 5; i++) begin
			for (int p = 0; p < 2; p++) begin
				wr(OFS_EDGE_POLARITY, 8'(p << i));
				wr(OFS_ENABLE_ONE, 8'(1 << i));
				line_to(i, ~p[0]);
				chk(src_req, 16'h0000, "unselected edge");
				line_to(i, p[0]);
				chk(src_req, 16'(1 << i), "selected edge");
				rchk(OFS_REQUEST_ONE, 8'(32'h20 | (1 << i)), "one flag per edge");
				wr(OFS_REQUEST_ONE, 8'h00);
				line_to(i, ~p[0]);
				chk(src_req, 16'h0000, "edge back");
			end
		end
		@(posedge mclk);
		ext_mode <= 5'h00;
		wr(OFS_EDGE_POLARITY, 8'h00);
		line_to(0, 1'b1);
		line_to(0, 1'b0);
		line_to(1, 1'b1);
		line_to(1, 1'b0);
		rchk(OFS_REQUEST_ONE, 8'h20, "pin not in interrupt mode");
		$display("test external lines done");
	endtask

	task automatic t_periph();
		int s;
		int b;
		logic [15:0] a;
		logic [15:0] q;
		for (int k = 0; k < 14; k++) begin
			s = src_of[k];
			b = s % 8;
			a = (s < 8) ? OFS_ENABLE_ONE : OFS_ENABLE_TWO;
			q = (s < 8) ? OFS_REQUEST_ONE : OFS_REQUEST_TWO;
			@(posedge mclk);
			cpu_mask <= 1'(k & 1);
			fire(k);
			chk(src_req, 16'h0000, "disabled source");
			rchk(q, 8'(((s < 8) ? 32'h20 : 32'h00) | (1 << b)), "flag while disabled");
			wr(a, 8'(1 << b));
			chk(src_req, 16'(1 << s), "enabled source");
			chk({15'h0, int_req}, {15'h0, ~cpu_mask}, "core request");
			wr(q, 8'hff);
			chk(src_req, 16'(1 << s), "write one keeps flag");
			wr(q, 8'h00);
			chk(src_req, 16'h0000, "write zero clears flag");
			wr(a, 8'h00);
		end
		wr(OFS_ENABLE_ONE, 8'h20);
		for (int w = 0; w < 8; w++) begin
			fire(14 + w);
			chk(src_req, 16'h0020, "wakeup common enable");
			rchk(OFS_WAKEUP_REQ, 8'(1 << w), "wakeup flag");
			wr(OFS_WAKEUP_REQ, 8'h00);
		end
		$display("test sources done");
	endtask

	// adc event reaches the flag in the same cycle as a clear of it
	task automatic t_clear_race();
		@(posedge mclk);
		fire_cmd <= 1'b1;
		sel <= 5'h01;
		@(posedge mclk);
		fire_cmd <= 1'b0;
		bus <= '{addr: OFS_REQUEST_TWO, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
		#1;
		rchk(OFS_REQUEST_TWO, 8'h40, "event beats clear");
		wr(OFS_REQUEST_TWO, 8'h00);
		rchk(OFS_REQUEST_TWO, 8'h00, "later clear works");
		$display("test clear race done");
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		$display("wrong value at %0t: run did not finish", $time);
		end_sim();
	end

	initial begin
		arst_n = 1'b0;
		bus = '0;
		ext_line = 5'h1f;
		ext_mode = 5'h1f;
		cpu_mask = 1'b0;
		fire_cmd = 1'b0;
		sel = 5'h00;
		err_count = 0;
		n_checks = 0;
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		t_reset();
		t_regs();
		t_ext();
		t_periph();
		t_clear_race();
		end_sim();
	end
endmodule // tb_irq_edge_select_and_enable
`default_nettype wire
